// >>> rtl/gpib_cmd_defs.vh
`ifndef GPIB_CMD_DEFS_VH
`define GPIB_CMD_DEFS_VH

// ====================================================================
// Multiline command codes, compared on the seven low data lines.
`define CMD_GO_LOCAL        7'h01
`define CMD_SEL_CLEAR       7'h04
`define CMD_TRIGGER         7'h08
`define CMD_LOCKOUT         7'h11
`define CMD_DEV_CLEAR       7'h14
`define CMD_POLL_ON         7'h18
`define CMD_POLL_OFF        7'h19
`define CMD_UNLISTEN        7'h3F
`define CMD_UNTALK          7'h5F

// ====================================================================
// Address groups: the top two of the seven bits select the group.
`define GRP_HI              6
`define GRP_LO              5
`define GRP_LISTEN          2'h1
`define GRP_TALK            2'h2
`define GRP_SECONDARY       2'h3
`define ADDR_HI             4
`define ADDR_LO             0

// ====================================================================
// Bit positions in the synchronised pin vector.
`define PIN_ATN             8
`define PIN_DAV             9
`define PIN_IFC             10
`define PIN_REN             11
`define PIN_COUNT           12

// ====================================================================
// Acceptor handshake states.
`define AH_READY            2'h0
`define AH_TAKE             2'h1
`define AH_DONE             2'h2

`endif

// >>> rtl/byte_skid_buffer.v
`timescale 1ns/100ps

module byte_skid_buffer #(
   parameter WIDTH = 8
) (
   // Clock and reset.
   input  wire             clk,
   input  wire             rst_n,
   input  wire             flush,
   // Filling side.
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // Draining side.
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);

   reg [WIDTH-1:0] slot_q [0:1];
   reg             rd_q;
   reg             wr_q;
   reg [1:0]       count_q;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data  = slot_q[rd_q];

   always @(posedge clk) begin
      if (!rst_n || flush) begin
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         case ({push, pop})
            2'b10:   count_q <= count_q + 2'h1;
            2'b01:   count_q <= count_q - 2'h1;
            default: count_q <= count_q;
         endcase
      end
   end

   always @(posedge clk) begin
      if (push) begin
         slot_q[wr_q] <= in_data;
      end
   end

endmodule // byte_skid_buffer

// >>> rtl/ieee488_command_decoder.v
// How it works
// - Universal commands act with ATN true whatever the addressing state.
// - Local lockout 0x11 locks the local key and front panel.
// - Device clear 0x14 pulses dev_clear_q, leaves serial poll mode and flushes the data buffer.
// - Serial poll enable 0x18 enters serial poll mode.
// - Serial poll disable 0x19 leaves serial poll mode, addressed or not.
// - Addressed commands act only while listen-addressed, else ignored.
// - Selective device clear 0x04, when listen-addressed, clears like device clear.
// - Go-to-local 0x01, when listen-addressed, leaves remote, may release lockout.
// - Group execute trigger 0x08 starts the configured triggered action.
// - Primary address ORed with 0x20 under ATN makes the device a listener.
// - Primary address ORed with 0x40 under ATN makes the device a talker.
// - Secondary group bytes 0x60 to 0x7F are ignored.
// - Unlisten 0x3F under ATN puts the device in listener idle.
// - Untalk 0x5F under ATN puts a talker into talker idle.
// - Bytes with ATN false go to the parser only while listening.
// - Bytes move under the interlocked DAV, NRFD, NDAC handshake.
// - Interface clear returns talker and listener to idle.
// - With remote enable asserted, the device goes remote once listen-addressed.
`timescale 1ns/100ps
`include "gpib_cmd_defs.vh"

module ieee488_command_decoder #(
   parameter GTL_UNLOCKS = 1
) (
   // Clock and reset.
   input  wire       clk,
   input  wire       rst_n,
   // Bus lines, active low, from the pins.
   input  wire [7:0] dio_n,
   input  wire       atn_n,
   input  wire       dav_n,
   input  wire       ifc_n,
   input  wire       ren_n,
   // Open-drain handshake lines driven by the acceptor.
   output wire       nrfd_n_out,
   output wire       nrfd_n_oe,
   output wire       ndac_n_out,
   output wire       ndac_n_oe,
   // Configuration.
   input  wire [4:0] primary_addr,
   // Device state.
   output reg        listen_q,
   output reg        talk_q,
   output reg        remote_q,
   output reg        lockout_q,
   output reg        poll_mode_q,
   output reg        dev_clear_q,
   output reg        trigger_q,
   // Device data to the command parser.
   output wire [7:0] data_out,
   output wire       data_valid,
   input  wire       data_ready
);

   // ================================================================
   // Pin synchronisers: three flops, a change counts once the second
   // and third stages agree.
   wire [`PIN_COUNT-1:0] pin_raw = {ren_n, ifc_n, dav_n, atn_n, dio_n};
   reg  [`PIN_COUNT-1:0] sync1_q;
   reg  [`PIN_COUNT-1:0] sync2_q;
   reg  [`PIN_COUNT-1:0] sync3_q;
   reg  [`PIN_COUNT-1:0] pin_q;

   always @(posedge clk) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
         always @(posedge clk) begin
            if (!rst_n) begin
               pin_q[gi] <= 1'b1;
            end else if (sync2_q[gi] == sync3_q[gi]) begin
               pin_q[gi] <= sync3_q[gi];
            end
         end
      end
   endgenerate

   wire       atn = ~pin_q[`PIN_ATN];
   wire       dav = ~pin_q[`PIN_DAV];
   wire       ifc = ~pin_q[`PIN_IFC];
   wire       ren = ~pin_q[`PIN_REN];
   wire [7:0] dio = ~pin_q[7:0];

   function is_cmd;
      input [6:0] b;
      input [6:0] code;
      begin
         is_cmd = (b == code);
      end
   endfunction

   // ================================================================
   // Acceptor handshake.
   reg  [1:0] ah_q;
   reg  [1:0] ah_d;
   reg  [7:0] byte_q;
   reg        byte_atn_q;
   wire       buf_ready;
   wire       push_data = (ah_q == `AH_TAKE) & ~byte_atn_q & listen_q;
   wire       ah_active = atn | listen_q;
   reg        nrfd_hold;
   reg        ndac_hold;

   always @* begin
      ah_d = ah_q;
      case (ah_q)
         `AH_READY: begin
            if (dav && ah_active) begin
               ah_d = `AH_TAKE;
            end
         end
         `AH_TAKE: begin
            if (!push_data || buf_ready) begin
               ah_d = `AH_DONE;
            end
         end
         `AH_DONE: begin
            if (!dav) begin
               ah_d = `AH_READY;
            end
         end
         default: ah_d = `AH_READY;
      endcase
   end

   // Ready for data only while idle and waiting; NDAC released once taken.
   always @* begin
      nrfd_hold = ah_active & (ah_q != `AH_READY);
      ndac_hold = ah_active & (ah_q != `AH_DONE);
      if (ah_q != `AH_READY) begin
         nrfd_hold = 1'b1;
         ndac_hold = (ah_q == `AH_TAKE);
      end
   end

   assign nrfd_n_out = 1'b0;
   assign nrfd_n_oe  = nrfd_hold;
   assign ndac_n_out = 1'b0;
   assign ndac_n_oe  = ndac_hold;

   always @(posedge clk) begin
      if (!rst_n || ifc) begin
         ah_q       <= `AH_READY;
         byte_q     <= 8'h00;
         byte_atn_q <= 1'b0;
      end else begin
         ah_q <= ah_d;
         if (ah_q == `AH_READY && ah_d == `AH_TAKE) begin
            byte_q     <= dio;
            byte_atn_q <= atn;
         end
      end
   end

   // ================================================================
   // Command decode, acted on once per accepted byte under ATN.
   wire [6:0] cb       = byte_q[6:0];
   wire [1:0] grp      = cb[`GRP_HI:`GRP_LO];
   wire [4:0] addr     = cb[`ADDR_HI:`ADDR_LO];
   wire       cmd_take = (ah_q == `AH_TAKE) & byte_atn_q;
   wire       is_mla   = (grp == `GRP_LISTEN) & (addr == primary_addr);
   wire       is_mta   = (grp == `GRP_TALK) & (addr == primary_addr);
   wire       is_unl   = is_cmd(cb, `CMD_UNLISTEN);
   wire       is_unt   = is_cmd(cb, `CMD_UNTALK);
   wire       is_ota   = (grp == `GRP_TALK) & ~is_mta & ~is_unt;
   wire       is_scg   = (grp == `GRP_SECONDARY);
   wire       clr_all  = cmd_take & (is_cmd(cb, `CMD_DEV_CLEAR)
                         | (listen_q & is_cmd(cb, `CMD_SEL_CLEAR)));

   always @(posedge clk) begin
      if (!rst_n) begin
         listen_q    <= 1'b0;
         talk_q      <= 1'b0;
         remote_q    <= 1'b0;
         lockout_q   <= 1'b0;
         poll_mode_q <= 1'b0;
         dev_clear_q <= 1'b0;
         trigger_q   <= 1'b0;
      end else begin
         dev_clear_q <= clr_all;
         trigger_q   <= cmd_take & listen_q & is_cmd(cb, `CMD_TRIGGER);
         if (ifc) begin
            listen_q <= 1'b0;
            talk_q   <= 1'b0;
         end else if (cmd_take && !is_scg) begin
            if (is_mla) begin
               listen_q <= 1'b1;
            end else if (is_unl) begin
               listen_q <= 1'b0;
            end
            if (is_mta) begin
               talk_q <= 1'b1;
            end else if (is_unt || is_ota) begin
               talk_q <= 1'b0;
            end
            if (is_cmd(cb, `CMD_POLL_ON)) begin
               poll_mode_q <= 1'b1;
            end else if (is_cmd(cb, `CMD_POLL_OFF)) begin
               poll_mode_q <= 1'b0;
            end
         end
         if (!ren) begin
            remote_q  <= 1'b0;
            lockout_q <= 1'b0;
         end else begin
            if (cmd_take && is_mla) begin
               remote_q <= 1'b1;
            end
            if (cmd_take && is_cmd(cb, `CMD_LOCKOUT)) begin
               lockout_q <= 1'b1;
            end
            if (cmd_take && listen_q && is_cmd(cb, `CMD_GO_LOCAL)) begin
               remote_q <= 1'b0;
               if (GTL_UNLOCKS != 0) begin
                  lockout_q <= 1'b0;
               end
            end
         end
         if (clr_all) begin
            poll_mode_q <= 1'b0;
         end
      end
   end

   // ================================================================
   // Data path to the command parser; a stall holds NDAC on the bus.
   byte_skid_buffer #(
      .WIDTH (8)
   ) u_data_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (clr_all),
      .in_data   (byte_q),
      .in_valid  (push_data),
      .in_ready  (buf_ready),
      .out_data  (data_out),
      .out_valid (data_valid),
      .out_ready (data_ready)
   );

endmodule // ieee488_command_decoder

// >>> dv/gpib_controller_model.sv
`timescale 1ns/100ps
module gpib_controller_model (
   // Clock.
   input  wire       clk,
   // Acceptor lines as seen on the bus.
   input  wire       nrfd_w,
   input  wire       ndac_w,
   // Lines the controller drives.
   output reg  [7:0] dio_n,
   output reg        atn_n,
   output reg        dav_n
);
   initial begin
      dio_n = 8'hFF;
      atn_n = 1'b1;
      dav_n = 1'b1;
   end
   // Sends one byte; after a bounded wait it goes on as other acceptors would let it.
   task automatic send(input logic [7:0] b, input logic atn);
      int i;
      @(negedge clk);
      atn_n = ~atn;
      dio_n = ~b;
      for (i = 0; i < 20 && !(nrfd_w && !ndac_w); i++) @(negedge clk);
      dav_n = 1'b0;
      for (i = 0; i < 300 && !ndac_w; i++) @(negedge clk);
      dav_n = 1'b1;
      for (i = 0; i < 20 && ndac_w; i++) @(negedge clk);
      dio_n = 8'hFF;
   endtask
endmodule // gpib_controller_model

// >>> dv/ieee488_command_decoder_monitor.sv
`timescale 1ns/100ps
module ieee488_command_decoder_monitor (
   // Clock and reset.
   input wire       clk,
   input wire       rst_n,
   // Bus lines.
   input wire [7:0] dio_n,
   input wire       atn_n,
   input wire       dav_n,
   input wire       ifc_n,
   input wire       ren_n,
   // Acceptor drives.
   input wire       nrfd_n_out,
   input wire       nrfd_n_oe,
   input wire       ndac_n_out,
   input wire       ndac_n_oe,
   // Configuration and state.
   input wire [4:0] primary_addr,
   input wire       listen_q,
   input wire       talk_q,
   input wire       remote_q,
   input wire       lockout_q,
   input wire       poll_mode_q,
   input wire       dev_clear_q,
   input wire       trigger_q,
   // Parser side.
   input wire [7:0] data_out,
   input wire       data_valid,
   input wire       data_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==================================================================
   // Handshake and state checks.
   sequence released_s;
      (nrfd_n_oe && !ndac_n_oe)[*3];
   endsequence
   hs_take_a: assert property ($rose(nrfd_n_oe) |-> ndac_n_oe && !dav_n) else $error("take order");
   hs_accept_a: assert property ($fell(ndac_n_oe) && nrfd_n_oe |-> released_s) else $error("accept order");
   hs_release_a: assert property ($fell(ndac_n_oe) && !nrfd_n_oe |-> !listen_q) else $error("early release");
   hs_quiet_a: assert property ((atn_n && dav_n && !listen_q)[*8] |-> !nrfd_n_oe && !ndac_n_oe)
      else $error("idle drives bus");
   addr_atn_a: assert property ($rose(talk_q) || $rose(listen_q) |-> !atn_n) else $error("address");
   clr_pulse_a: assert property (dev_clear_q |-> !poll_mode_q ##1 !dev_clear_q) else $error("clear");
   trig_addr_a: assert property (trigger_q |-> listen_q ##1 !trigger_q) else $error("trigger");
   ifc_idle_a: assert property (!ifc_n[*7] |-> !listen_q && !talk_q) else $error("ifc");
   ren_local_a: assert property (ren_n[*7] |-> !remote_q && !lockout_q) else $error("local");
   data_hold_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data_out))
      else $error("data hold");
   data_listen_a: assert property ($rose(data_valid) |-> listen_q) else $error("data source");
endmodule // ieee488_command_decoder_monitor
bind ieee488_command_decoder ieee488_command_decoder_monitor u_monitor (.*);

// >>> dv/tb_ieee488_command_decoder.sv
`timescale 1ns/100ps
module tb_ieee488_command_decoder;
   // ==================================================================
   // Bench signals.
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       ifc_n = 1'b1;
   logic       ren_n = 1'b0;
   logic       data_ready = 1'b0;
   logic [1:0] clr_cnt = 2'h0;
   logic       trig_cnt = 1'b0;
   logic [4:0] paddr = 5'h16;
   int         bad_count = 0;
   int         n_checks = 0;
   wire  [7:0] dio_n;
   wire        atn_n, dav_n, nrfd_n_out, nrfd_n_oe, ndac_n_out, ndac_n_oe;
   wire        listen_q, talk_q, remote_q, lockout_q, poll_mode_q, dev_clear_q, trigger_q;
   wire  [7:0] data_out;
   wire        data_valid;
   wire        nrfd_w = nrfd_n_oe ? nrfd_n_out : 1'b1;
   wire        ndac_w = ndac_n_oe ? ndac_n_out : 1'b1;
   wire  [7:0] st = {clr_cnt, trig_cnt, listen_q, talk_q, remote_q, lockout_q, poll_mode_q};

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (dev_clear_q === 1'b1) clr_cnt <= clr_cnt + 2'h1;
      if (trigger_q === 1'b1) trig_cnt <= ~trig_cnt;
   end

   ieee488_command_decoder u_dut (.clk(clk), .rst_n(rst_n), .dio_n(dio_n), .atn_n(atn_n), .dav_n(dav_n),
      .ifc_n(ifc_n), .ren_n(ren_n), .nrfd_n_out(nrfd_n_out), .nrfd_n_oe(nrfd_n_oe), .ndac_n_out(ndac_n_out),
      .ndac_n_oe(ndac_n_oe), .primary_addr(paddr), .listen_q(listen_q), .talk_q(talk_q), .remote_q(remote_q),
      .lockout_q(lockout_q), .poll_mode_q(poll_mode_q), .dev_clear_q(dev_clear_q), .trigger_q(trigger_q),
      .data_out(data_out), .data_valid(data_valid), .data_ready(data_ready));
   gpib_controller_model u_ctl (.clk(clk), .nrfd_w(nrfd_w), .ndac_w(ndac_w), .dio_n(dio_n), .atn_n(atn_n),
      .dav_n(dav_n));

   // ==================================================================
   // Tasks.
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task step(input logic a, input logic [7:0] b, input logic [7:0] e);
      u_ctl.send(b, a);
      repeat (2) @(negedge clk);
      check("state", st, e);
   endtask
   task pop(input logic [7:0] e);
      int i;
      @(negedge clk);
      for (i = 0; i < 300 && data_valid !== 1'b1; i++) @(negedge clk);
      check("data", data_out, e);
      data_ready = 1'b1;
      @(negedge clk);
      data_ready = 1'b0;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ==================================================================
   // Tests.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      finish_test;
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("reset", {nrfd_n_oe, ndac_n_oe, data_valid, st[4:0]}, 8'h00);
      check("drive level", {6'h00, nrfd_n_out, ndac_n_out}, 8'h00);
      step(1'b1, 8'h3F, 8'h00);
      step(1'b1, 8'h08, 8'h00);
      step(1'b1, 8'h04, 8'h00);
      step(1'b0, 8'h41, 8'h00);
      check("ignored", {7'h00, data_valid}, 8'h00);
      step(1'b1, 8'hB6, 8'h14);
      step(1'b1, 8'h76, 8'h14);
      step(1'b1, 8'h11, 8'h16);
      step(1'b1, 8'h08, 8'h36);
      step(1'b1, 8'h18, 8'h37);
      step(1'b1, 8'h19, 8'h36);
      step(1'b1, 8'h01, 8'h30);
      step(1'b1, 8'h04, 8'h70);
      step(1'b1, 8'h18, 8'h71);
      step(1'b1, 8'h14, 8'hB0);
      step(1'b1, 8'h56, 8'hB8);
      step(1'b1, 8'h45, 8'hB0);
      step(1'b1, 8'h56, 8'hB8);
      step(1'b1, 8'h5F, 8'hB0);
      step(1'b1, 8'h3F, 8'hA0);
      step(1'b1, 8'h18, 8'hA1);
      step(1'b1, 8'h19, 8'hA0);
      step(1'b1, 8'h14, 8'hE0);
      step(1'b1, 8'h36, 8'hF4);
      fork
         begin
            u_ctl.send(8'h2A, 1'b0);
            u_ctl.send(8'h52, 1'b0);
            u_ctl.send(8'h53, 1'b0);
         end
         begin
            repeat (150) @(negedge clk);
            check("stall", {6'h00, nrfd_n_oe, ndac_n_oe}, 8'h03);
            pop(8'h2A);
            pop(8'h52);
            pop(8'h53);
         end
      join
      step(1'b1, 8'h56, 8'hFC);
      ifc_n = 1'b0;
      repeat (8) @(negedge clk);
      ifc_n = 1'b1;
      check("ifc", st, 8'hE4);
      ren_n = 1'b1;
      repeat (8) @(negedge clk);
      check("ren", st, 8'hE0);
      paddr = 5'h05;
      step(1'b1, 8'h25, 8'hF0);
      step(1'b1, 8'h45, 8'hF8);
      finish_test;
   end
endmodule // tb_ieee488_command_decoder
